//--- rtl/gp_gpio_port.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module gp_gpio_port
    import gp_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // standby controller and external interrupt circuit
    input wire logic standby_entry,
    input wire logic [7:0] p0_irq_en,
    input wire logic [7:0] p1_irq_en,
    // on-chip peripheral outputs
    input wire logic [7:0] p0_periph_oe,
    input wire logic [7:0] p0_periph_out,
    input wire logic [7:0] p1_periph_oe,
    input wire logic [7:0] p1_periph_out,
    // port 0 pins
    input wire logic [7:0] p0_pin_in,
    output logic [7:0] p0_pin_out,
    output logic [7:0] p0_pin_oe,
    output logic [7:0] p0_pullup_on,
    // port 1 pins
    input wire logic [7:0] p1_pin_in,
    output logic [7:0] p1_pin_out,
    output logic [7:0] p1_pin_oe,
    output logic [7:0] p1_pullup_on,
    // levels towards peripherals
    output logic [7:0] p0_ext_irq_level,
    output logic [7:0] p1_ext_irq_level,
    output logic [7:0] p0_periph_in,
    output logic [7:0] p1_periph_in,
    output logic comparator_plus_input_en,
    output logic comparator_minus_input_en
);
    logic [7:0] port0_output_latch;
    logic [7:0] port0_pin_direction;
    logic [7:0] port0_pullup_enable;
    logic [7:0] analog_input_disable_low;
    logic [7:0] port1_output_latch;
    logic [7:0] port1_pin_direction;
    logic [7:0] port1_pullup_enable;
    logic standby_pin_state_select;
    logic comparator_input_disable;
    logic [15:0] pin_sync;
    logic [7:0] p0_sync;
    logic [7:0] p1_sync;
    logic park;
    logic hold;
    logic [7:0] p0_block;
    logic [7:0] p1_block;
    logic [7:0] p0_level;
    logic [7:0] p1_level;
    logic wr_access;
    logic rd_setup;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [7:0] next_p0_oe;
    logic [7:0] next_p0_val;
    logic [7:0] next_p1_oe;
    logic [7:0] next_p1_val;

    // port driver: peripheral wins, else the output latch value is driven
    function automatic logic [7:0] drive_val(input logic [7:0] poe, input logic [7:0] pout,
                                             input logic [7:0] latch);
        drive_val = (poe & pout) | (~poe & latch);
    endfunction

    // open-drain pins release the line instead of driving high
    function automatic logic [7:0] drive_oe(input logic [7:0] dir, input logic [7:0] poe,
                                            input logic [7:0] val, input logic [7:0] od);
        drive_oe = (dir | poe) & ~(od & val);
    endfunction

    // data read: latch for a pure output port, pin level otherwise
    function automatic logic [7:0] read_val(input logic [7:0] dir, input logic [7:0] poe,
                                            input logic [7:0] latch, input logic [7:0] level);
        logic [7:0] own;
        own = dir & ~poe;
        read_val = (own & latch) | (~own & level);
    endfunction

    // pins cross two flip-flops before any use
    gp_sync2 #(
        .W(16)
    ) u_pin_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({p1_pin_in, p0_pin_in}),
        .q(pin_sync)
    );

    assign p0_sync = pin_sync[7:0];
    assign p1_sync = pin_sync[15:8];

    assign park = standby_entry & standby_pin_state_select;
    assign hold = standby_entry & ~standby_pin_state_select;

    // parked inputs are blocked unless their interrupt is enabled
    assign p0_block = park ? ~p0_irq_en : 8'h00;
    assign p1_block = park ? ~p1_irq_en : 8'h00;

    // digital path of analog-shared port 0 pins needs the disable bit set
    assign p0_level = p0_sync & analog_input_disable_low & ~p0_block;
    assign p1_level = p1_sync & ~p1_block;

    assign wr_access = psel & penable & pwrite & pready;
    assign rd_setup = psel & ~penable & ~pwrite;

    // port 0 registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port0_output_latch <= GP_LATCH_RST;
            port0_pin_direction <= GP_DIR_RST;
            port0_pullup_enable <= GP_PULL_RST;
            analog_input_disable_low <= GP_AIN_DIS_RST;
        end else if (wr_access) begin
            unique case (paddr)
                GP_P0_LATCH_OFF: port0_output_latch <= pwdata[7:0];
                GP_P0_DIR_OFF: port0_pin_direction <= pwdata[7:0];
                GP_P0_PULL_OFF: port0_pullup_enable <= pwdata[7:0];
                GP_AIN_DIS_OFF: analog_input_disable_low <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // port 1 registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_output_latch <= GP_LATCH_RST;
            port1_pin_direction <= GP_DIR_RST;
            port1_pullup_enable <= GP_PULL_RST;
        end else if (wr_access) begin
            unique case (paddr)
                GP_P1_LATCH_OFF: port1_output_latch <= pwdata[7:0];
                GP_P1_DIR_OFF: port1_pin_direction <= pwdata[7:0];
                GP_P1_PULL_OFF: port1_pullup_enable <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // standby and comparator control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_pin_state_select <= GP_CTRL_RST[GP_CTRL_SPL_BIT];
            comparator_input_disable <= GP_CTRL_RST[GP_CTRL_CID_BIT];
        end else if (wr_access && paddr == GP_CTRL_OFF) begin
            standby_pin_state_select <= pwdata[GP_CTRL_SPL_BIT];
            comparator_input_disable <= pwdata[GP_CTRL_CID_BIT];
        end
    end

    // read data and error, prepared in the setup cycle
    always_comb begin
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            GP_P0_LATCH_OFF: next_prdata[7:0] = read_val(port0_pin_direction, p0_periph_oe,
                                                         port0_output_latch, p0_level);
            GP_P0_DIR_OFF: next_prdata[7:0] = port0_pin_direction;
            GP_P0_PULL_OFF: next_prdata[7:0] = port0_pullup_enable;
            GP_AIN_DIS_OFF: next_prdata[7:0] = analog_input_disable_low;
            GP_P1_LATCH_OFF: next_prdata[7:0] = read_val(port1_pin_direction, p1_periph_oe,
                                                         port1_output_latch, p1_level);
            GP_P1_DIR_OFF: next_prdata[7:0] = port1_pin_direction;
            GP_P1_PULL_OFF: next_prdata[7:0] = port1_pullup_enable;
            GP_CTRL_OFF: begin
                next_prdata[GP_CTRL_SPL_BIT] = standby_pin_state_select;
                next_prdata[GP_CTRL_CID_BIT] = comparator_input_disable;
            end
            GP_P0_RMW_OFF: next_prdata[7:0] = port0_output_latch;
            GP_P1_RMW_OFF: next_prdata[7:0] = port1_output_latch;
            default: next_pslverr = 1'b1;
        endcase
    end

    // apb answer: one access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & next_pslverr;
            if (rd_setup) begin
                prdata <= next_prdata;
            end
        end
    end

    // pad drive computation
    always_comb begin
        next_p0_val = drive_val(p0_periph_oe, p0_periph_out, port0_output_latch);
        next_p1_val = drive_val(p1_periph_oe, p1_periph_out, port1_output_latch);
        next_p0_oe = drive_oe(port0_pin_direction, p0_periph_oe, next_p0_val,
                              GP_P0_OD_MASK);
        next_p1_oe = drive_oe(port1_pin_direction, p1_periph_oe, next_p1_val,
                              GP_P1_OD_MASK);
    end

    // pads: parked pins float, held pins freeze, others follow the drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_pin_out <= 8'h00;
            p0_pin_oe <= 8'h00;
            p1_pin_out <= 8'h00;
            p1_pin_oe <= 8'h00;
        end else if (park) begin
            p0_pin_oe <= 8'h00;
            p1_pin_oe <= 8'h00;
        end else if (!hold) begin
            p0_pin_out <= next_p0_val;
            p0_pin_oe <= next_p0_oe;
            p1_pin_out <= next_p1_val;
            p1_pin_oe <= next_p1_oe;
        end
    end

    // pull-ups follow their enables (port 1 bit 2 has none) but drop while the pin drives low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_pullup_on <= 8'h00;
            p1_pullup_on <= 8'h00;
        end else if (park) begin
            p0_pullup_on <= port0_pullup_enable & GP_P0_PULL_MASK;
            p1_pullup_on <= port1_pullup_enable & GP_P1_PULL_MASK;
        end else if (!hold) begin
            p0_pullup_on <= port0_pullup_enable & GP_P0_PULL_MASK
                            & ~(next_p0_oe & ~next_p0_val);
            p1_pullup_on <= port1_pullup_enable & GP_P1_PULL_MASK
                            & ~(next_p1_oe & ~next_p1_val);
        end
    end

    // levels towards interrupt circuit and peripherals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_ext_irq_level <= 8'h00;
            p1_ext_irq_level <= 8'h00;
            p0_periph_in <= 8'h00;
            p1_periph_in <= 8'h00;
        end else begin
            p0_ext_irq_level <= p0_sync & ~p0_block;
            p1_ext_irq_level <= p1_sync & ~p1_block;
            p0_periph_in <= p0_level;
            p1_periph_in <= p1_level;
        end
    end

    // comparator inputs on port 0 bits 0 and 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_plus_input_en <= 1'b0;
            comparator_minus_input_en <= 1'b0;
        end else begin
            comparator_plus_input_en <= ~comparator_input_disable;
            comparator_minus_input_en <= ~comparator_input_disable;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [11:0] off);
        psel && penable && pwrite && pready && paddr == off;
    endsequence

    sequence s_rd(logic [11:0] off);
        psel && !penable && !pwrite && paddr == off;
    endsequence

    dir_reset_a: assert property (
        !$past(presetn) |-> port0_pin_direction == 8'h00 && port1_pin_direction == 8'h00)
        else $error("direction not cleared by reset");

    input_undriven_a: assert property (
        !park && !hold |=> (p0_pin_oe & ~$past(port0_pin_direction | p0_periph_oe)) == 8'h00)
        else $error("input pin driven");

    latch_write_a: assert property (
        s_wr(GP_P0_LATCH_OFF) |=> port0_output_latch == $past(pwdata[7:0]))
        else $error("latch write lost");

    dir_write_a: assert property (
        s_wr(GP_P1_DIR_OFF) ##1 (!park && !hold) |=>
        ((p1_pin_oe ^ $past(port1_pin_direction, 1)) & $past(port1_pin_direction) &
         ~GP_P1_OD_MASK) == 8'h00)
        else $error("output direction not applied");

    pin_read_a: assert property (
        s_rd(GP_P0_LATCH_OFF) |=>
        ((prdata[7:0] ^ $past(p0_level)) & ~$past(port0_pin_direction)) == 8'h00)
        else $error("input pin read wrong");

    rmw_read_a: assert property (
        s_rd(GP_P1_RMW_OFF) |=> prdata[7:0] == $past(port1_output_latch) && !pslverr)
        else $error("rmw read not latch");

    periph_drive_a: assert property (
        !park && !hold |=> ((p0_pin_out ^ $past(p0_periph_out)) & $past(p0_periph_oe)) == 8'h00)
        else $error("peripheral not driving pin");

    park_hiz_a: assert property (
        park |=> p0_pin_oe == 8'h00 && p1_pin_oe == 8'h00 &&
        (p0_periph_in & ~$past(p0_irq_en)) == 8'h00)
        else $error("parked pin not floating");

    park_irq_a: assert property (
        park |=> ((p0_ext_irq_level ^ $past(p0_sync)) & $past(p0_irq_en)) == 8'h00)
        else $error("interrupt input blocked");

    hold_level_a: assert property (
        hold [*2] |-> $stable(p0_pin_out) && $stable(p0_pin_oe) && $stable(p1_pin_out))
        else $error("standby hold changed pin");

    pullup_low_a: assert property (
        (p0_pullup_on & p0_pin_oe & ~p0_pin_out) == 8'h00 &&
        (p1_pullup_on & p1_pin_oe & ~p1_pin_out) == 8'h00)
        else $error("pull-up on low-driven pin");

    analog_gate_a: assert property (
        1 |=> (p0_periph_in & ~$past(analog_input_disable_low)) == 8'h00)
        else $error("digital input not disabled");

    cmp_enable_a: assert property (
        s_wr(GP_CTRL_OFF) ##1 1 |=> comparator_plus_input_en == !$past(pwdata[GP_CTRL_CID_BIT], 2))
        else $error("comparator enable wrong");
endmodule // gp_gpio_port

//--- rtl/gp_pkg.sv
package gp_pkg;
    // port geometry
    localparam int GP_PORT_W = 8;
    localparam int GP_ADDR_W = 12;

    // register byte offsets on the apb window
    localparam logic [11:0] GP_P0_LATCH_OFF = 12'h000;
    localparam logic [11:0] GP_P0_DIR_OFF = 12'h004;
    localparam logic [11:0] GP_P0_PULL_OFF = 12'h008;
    localparam logic [11:0] GP_AIN_DIS_OFF = 12'h00C;
    localparam logic [11:0] GP_P1_LATCH_OFF = 12'h010;
    localparam logic [11:0] GP_P1_DIR_OFF = 12'h014;
    localparam logic [11:0] GP_P1_PULL_OFF = 12'h018;
    localparam logic [11:0] GP_CTRL_OFF = 12'h01C;
    // read-modify-write views of the data registers (read only)
    localparam logic [11:0] GP_P0_RMW_OFF = 12'h020;
    localparam logic [11:0] GP_P1_RMW_OFF = 12'h024;

    // control register fields
    localparam int GP_CTRL_SPL_BIT = 0;
    localparam int GP_CTRL_CID_BIT = 1;

    // reset values
    localparam logic [7:0] GP_LATCH_RST = 8'h00;
    localparam logic [7:0] GP_DIR_RST = 8'h00;
    localparam logic [7:0] GP_PULL_RST = 8'h00;
    localparam logic [7:0] GP_AIN_DIS_RST = 8'h00;
    localparam logic [1:0] GP_CTRL_RST = 2'h0;

    // pin properties
    localparam logic [7:0] GP_P0_OD_MASK = 8'h00;
    localparam logic [7:0] GP_P1_OD_MASK = 8'h00;
    localparam logic [7:0] GP_P0_PULL_MASK = 8'hFF;
    localparam logic [7:0] GP_P1_PULL_MASK = 8'hFB;
endpackage

//--- rtl/gp_sync2.sv
`timescale 1ns/1ps
module gp_sync2 #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous input and its synchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // gp_sync2

//--- verif/gp_board.sv
`timescale 1ns/1ps
module gp_board (
    // clock
    input wire logic clk,
    // pad side of the port
    input wire logic [7:0] drv,
    input wire logic [7:0] oe,
    input wire logic [7:0] pu,
    // external source on the board
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin
);
    logic [7:0] drift = 8'h5A;
    // a floating pin wanders so no stale level is read back
    always @(posedge clk) drift <= ~drift;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe[i]) pin[i] = drv[i];
            else if (ext_en[i]) pin[i] = ext_val[i];
            else if (pu[i]) pin[i] = 1'b1;
            else pin[i] = drift[i];
        end
    end
endmodule // gp_board

//--- verif/gp_gpio_port_test.sv
`timescale 1ns/1ps
module gp_gpio_port_test;
    import gp_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic standby_entry = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmp_p;
    logic cmp_n;
    logic [1:0][7:0] irq_en = '0, poe = '0, pout = '0, ext_val = '0, ext_en = '1;
    logic [1:0][7:0] pin_in, pin_out, pin_oe, pu_on, irq_lvl, per_in;
    logic [31:0] r;
    logic e;
    int err_total = 0;
    int checks_done = 0;
    int m[8];
    always #20 pclk = ~pclk;

    gp_gpio_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby_entry(standby_entry), .p0_irq_en(irq_en[0]),
        .p1_irq_en(irq_en[1]), .p0_periph_oe(poe[0]), .p0_periph_out(pout[0]),
        .p1_periph_oe(poe[1]), .p1_periph_out(pout[1]), .p0_pin_in(pin_in[0]),
        .p0_pin_out(pin_out[0]), .p0_pin_oe(pin_oe[0]), .p0_pullup_on(pu_on[0]),
        .p1_pin_in(pin_in[1]), .p1_pin_out(pin_out[1]), .p1_pin_oe(pin_oe[1]),
        .p1_pullup_on(pu_on[1]), .p0_ext_irq_level(irq_lvl[0]),
        .p1_ext_irq_level(irq_lvl[1]), .p0_periph_in(per_in[0]), .p1_periph_in(per_in[1]),
        .comparator_plus_input_en(cmp_p), .comparator_minus_input_en(cmp_n));
    gp_board bd0_u (.clk(pclk), .drv(pin_out[0]), .oe(pin_oe[0]), .pu(pu_on[0]),
        .ext_val(ext_val[0]), .ext_en(ext_en[0]), .pin(pin_in[0]));
    gp_board bd1_u (.clk(pclk), .drv(pin_out[1]), .oe(pin_oe[1]), .pu(pu_on[1]),
        .ext_val(ext_val[1]), .ext_en(ext_en[1]), .pin(pin_in[1]));

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, output logic [31:0] rd,
        output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) begin
            err_total++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(logic [11:0] a, logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, r, e);
        chk("write_err", e, 0);
        if (a < 12'h020) m[a >> 2] = d;
    endtask

    task automatic rd(logic [11:0] a, logic [31:0] exp, logic [31:0] msk, string nm);
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r & msk, exp & msk);
    endtask

    task automatic settle;
        repeat (6) @(posedge pclk);
    endtask

    task automatic check_port(int p, logic pk);
        logic [7:0] oe, out, lvl, gin, msk;
        oe = pk ? 8'h00 : (m[4*p+1][7:0] | poe[p]);
        out = (poe[p] & pout[p]) | (~poe[p] & m[4*p][7:0]);
        lvl = (oe & out) | (~oe & ext_val[p]);
        msk = (p == 0) ? m[3][7:0] : 8'hFF;
        gin = pk ? (lvl & irq_en[p]) : lvl;
        chk("pin_oe", pin_oe[p], oe);
        if (!pk) chk("pin_out", pin_out[p], out);
        chk("pullup", pu_on[p], m[4*p+2] & (p == 0 ? GP_P0_PULL_MASK : GP_P1_PULL_MASK)
            & ~(oe & ~out));
        chk("irq_level", irq_lvl[p], gin);
        chk("periph_in", per_in[p], gin & msk);
        if (!pk) begin
            // digital reads only where the analog path was disabled first
            rd(12'(p*16), lvl, msk, "plain_read");
            rd(12'(32 + p*4), m[4*p], 32'h0FF, "rmw_read");
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        err_total++;
        stop_test();
    end

    initial begin
        r = $urandom(32'h758A0765);
        foreach (m[i]) m[i] = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        for (int i = 0; i < 8; i++) rd(12'(i*4), 0, 32'hFFFFFFFF, "reset_value");
        chk("cmp_reset", {cmp_p, cmp_n}, 2'h3);
        check_port(0, 1'b0);
        check_port(1, 1'b0);
        apb(1'b0, 12'h030, 32'h0, r, e);
        chk("unmapped_err", e, 1);
        chk("unmapped_data", r, 0);
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 8; i++) wr(12'(i*4), i == 7 ? 8'($urandom & 3) : 8'($urandom));
            poe <= 16'($urandom);
            pout <= 16'($urandom);
            ext_val <= 16'($urandom);
            irq_en <= 16'($urandom);
            settle();
            check_port(0, 1'b0);
            check_port(1, 1'b0);
            chk("cmp_en", {cmp_p, cmp_n}, {2{!m[7][1]}});
        end
        // undriven input pins with pull-up read high
        poe <= '0;
        wr(GP_P0_DIR_OFF, 8'h00);
        wr(GP_P0_PULL_OFF, 8'hFF);
        wr(GP_AIN_DIS_OFF, 8'hFF);
        ext_en[0] <= 8'h00;
        settle();
        rd(GP_P0_LATCH_OFF, 32'hFF, 32'hFFFFFFFF, "pullup_read");
        ext_en[0] <= 8'hFF;
        wr(GP_P0_DIR_OFF, 8'hFF);
        wr(GP_P1_DIR_OFF, 8'hFF);
        wr(GP_CTRL_OFF, 8'h01);
        standby_entry <= 1'b1;
        settle();
        check_port(0, 1'b1);
        check_port(1, 1'b1);
        standby_entry <= 1'b0;
        wr(GP_CTRL_OFF, 8'h00);
        wr(GP_P0_LATCH_OFF, 8'hA5);
        settle();
        check_port(0, 1'b0);
        wr(GP_P0_LATCH_OFF, 8'h5A);
        // look between edges, where the pad register has settled
        @(negedge pclk);
        chk("pad_delay", pin_out[0], 8'hA5);
        @(negedge pclk);
        chk("pad_update", pin_out[0], 8'h5A);
        standby_entry <= 1'b1;
        settle();
        wr(GP_P0_LATCH_OFF, 8'h3C);
        settle();
        chk("hold_out", pin_out[0], 8'h5A);
        chk("hold_oe", pin_oe[0], 8'hFF);
        standby_entry <= 1'b0;
        settle();
        check_port(0, 1'b0);
        // port 0 set up for analog and interrupt use: input, no drive, no pull-up
        poe <= '0;
        ext_val <= 16'($urandom);
        wr(GP_P0_DIR_OFF, 8'h00);
        wr(GP_P0_PULL_OFF, 8'h00);
        wr(GP_AIN_DIS_OFF, 8'h00);
        settle();
        check_port(0, 1'b0);
        chk("cmp_analog", {cmp_p, cmp_n}, {2{!m[7][1]}});
        stop_test();
    end
endmodule // gp_gpio_port_test
